// ===== hdl/scp_pkg.sv
// Constants of the serial configuration port and its register bank.
// Assumes one 250 MHz clock; all serial pins are sampled by that clock.
package scp_pkg;
    // Register offsets
    localparam logic [4:0] ADDR_CLOCK_MODE = 5'h00;
    localparam logic [4:0] ADDR_CTRL_01    = 5'h01;
    localparam logic [4:0] ADDR_ALARM      = 5'h02;
    localparam logic [4:0] ADDR_INTERFACE  = 5'h03;
    localparam logic [4:0] ADDR_POWER_DOWN = 5'h06;
    localparam logic [4:0] ADDR_OFFSET_I_L = 5'h08;
    localparam logic [4:0] ADDR_OFFSET_Q_L = 5'h09;
    localparam logic [4:0] ADDR_OFFSET_I_H = 5'h0A;
    localparam logic [4:0] ADDR_OFFSET_Q_H = 5'h0B;
    localparam logic [4:0] ADDR_GAIN_I_L   = 5'h0C;
    localparam logic [4:0] ADDR_GAIN_Q_L   = 5'h0D;
    localparam logic [4:0] ADDR_PHASE_L    = 5'h0E;
    localparam logic [4:0] ADDR_GAIN_PH_H  = 5'h0F;
    localparam logic [4:0] ADDR_LAST_LOW   = 5'h10;
    localparam logic [4:0] ADDR_CTRL_17    = 5'h17;
    localparam int         REG_COUNT_DEF   = 24;
    // clock_mode_ctrl fields
    localparam int BIT_DIV_SYNC_EN   = 7;
    localparam int BIT_CLK_DRIVE_N   = 5;
    localparam int BIT_DATA_TYPE     = 3;
    localparam int BIT_FIFO_ENABLE   = 2;
    localparam int BIT_SYNC_PHASE    = 1;
    // ctrl_reg_01 clock mode field, bits 1:0
    localparam logic [1:0] MODE_DUAL_IN  = 2'h0;
    localparam logic [1:0] MODE_DUAL_OUT = 2'h1;
    // fifo_alarm_flags fields
    localparam int BIT_NEAR_TWO = 0;
    localparam int BIT_NEAR_ONE = 1;
    // interface_select fields
    localparam int         BIT_ALARM_ON_PIN = 7;
    localparam int         BIT_FOUR_WIRE    = 6;
    localparam int         POS_PIN_FUNC     = 4;
    localparam logic [1:0] PIN_FUNC_SYNC    = 2'h2;
    localparam logic [1:0] PIN_FUNC_SLEEP   = 2'h1;
    // power_down_ctrl fields
    localparam int BIT_PD_DIFF  = 7;
    localparam int BIT_PD_RF    = 6;
    localparam int BIT_PD_CONV  = 5;
    localparam int BIT_PD_CHAIN = 4;
    localparam int BIT_AL_DIFF  = 3;
    localparam int BIT_AL_RF    = 2;
    localparam int BIT_AL_CONV  = 1;
    localparam int BIT_SLEEP    = 0;
    // Reset values and pin sampler layout
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int         PIN_COUNT = 7;
    localparam logic [6:0] PIN_RESET = 7'h02;   // Frame enable idles high
    localparam int PIN_SCLK = 0;
    localparam int PIN_FRAME_N = 1;
    localparam int PIN_SDIO = 2;
    localparam int PIN_IQ_MARK = 3;
    localparam int PIN_SYNC_SLEEP = 4;
    localparam int PIN_NEAR_TWO = 5;
    localparam int PIN_NEAR_ONE = 6;
    // Serial engine states
    typedef enum logic [1:0] {
        ST_INSTR = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10,
        ST_TAIL  = 2'b11
    } scp_state_e;
endpackage : scp_pkg

// ===== hdl/scp_serial_config_port.sv
// Serial configuration port, register bank and the control outputs it steers.
// Assumes the host drives sclk, frame enable and write data slow enough that
// three-flop sampling at 250 MHz sees every serial clock level.
`timescale 1ns/1ns

// How it works
// - Instruction top bit high reads, low writes
// - Two-bit count gives bytes; data MSB first
// - Five-bit start address, decremented per byte
// - Frame enable low; data taken on rising sclk
// - Data pin is input during instruction byte
// - Three-wire read drives data pin, alarm pin released
// - Four-wire read uses alarm pin, then low tail
// - Normal registers take all eight bits together
// - Unmapped offsets ignore writes
// - Set flag bits stay until written zero
// - Near-two alarm flag is sticky
// - Near-one alarm flag is sticky
// - Divider phase follows marker when enabled
// - Latch clock driven when drive bit zero
// - FIFO enabled only in dual-input mode
// - Sync taken on I phase or Q forwarded
// - Data-type bit selects phase data mode
// - Power-down bits shut individual stages
// - Sleep shuts only stages whose allow bit set
// - Offsets commit together on I low offset write
// - Gains and phase commit on I low gain write
// - Frame is instruction plus one to four bytes
// - Read data shifted out on falling sclk
// - Interface register bit six picks four-wire
// - First frame byte is the instruction
module scp_serial_config_port #(
    parameter int REG_COUNT = scp_pkg::REG_COUNT_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        frame_enable_n_i,
    input  wire logic        sdio_i,
    output logic             sdio_o,
    output logic             sdio_oe_o,
    output logic             alarm_sdo_o,
    output logic             alarm_sdo_oe_o,
    input  wire logic        iq_phase_marker_i,
    input  wire logic        sync_sleep_i,
    input  wire logic        fifo_near_two_i,
    input  wire logic        fifo_near_one_i,
    output logic             sample_phase_q_o,
    output logic             sync_pulse_o,
    output logic             data_clock_oe_o,
    output logic             fifo_active_o,
    output logic             phase_data_mode_o,
    output logic             diff_out_pd_o,
    output logic             rf_stage_pd_o,
    output logic             converter_pd_o,
    output logic             analog_chain_pd_o,
    output logic [12:0]      offset_i_o,
    output logic [12:0]      offset_q_o,
    output logic [10:0]      gain_i_o,
    output logic [10:0]      gain_q_o,
    output logic [9:0]       phase_corr_o
);
    // Bank must hold offsets up to the last control register
    if (REG_COUNT < 24 || REG_COUNT > 32) begin : g_bad_count
        $error("REG_COUNT must lie between 24 and 32");
    end

    // Pin samplers: three flops, value accepted when stages two and three agree
    logic [6:0] s1_q, s2_q, s3_q, pin_q, pin_d;
    logic [6:0] pin_prev_q;

    always_comb
    begin
        pin_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q       <= scp_pkg::PIN_RESET;
            s2_q       <= scp_pkg::PIN_RESET;
            s3_q       <= scp_pkg::PIN_RESET;
            pin_q      <= scp_pkg::PIN_RESET;
            pin_prev_q <= scp_pkg::PIN_RESET;
        end
        else
        begin
            s1_q       <= {fifo_near_one_i, fifo_near_two_i, sync_sleep_i, iq_phase_marker_i,
                           sdio_i, frame_enable_n_i, sclk_i};
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            pin_q      <= pin_d;
            pin_prev_q <= pin_q;
        end
    end

    logic sclk_rise, sclk_fall, frame_idle, din, marker_rise;
    assign sclk_rise   = pin_q[scp_pkg::PIN_SCLK] & ~pin_prev_q[scp_pkg::PIN_SCLK];
    assign sclk_fall   = ~pin_q[scp_pkg::PIN_SCLK] & pin_prev_q[scp_pkg::PIN_SCLK];
    assign frame_idle  = pin_q[scp_pkg::PIN_FRAME_N];
    assign din         = pin_q[scp_pkg::PIN_SDIO];
    assign marker_rise = pin_q[scp_pkg::PIN_IQ_MARK] & ~pin_prev_q[scp_pkg::PIN_IQ_MARK];

    // Serial engine and register bank state
    scp_pkg::scp_state_e st_q, st_d;
    logic [5:0]  cnt_q, cnt_d, total;
    logic [7:0]  ish_q, ish_d, osh_q, osh_d;
    logic [4:0]  addr_q, addr_d;
    logic [1:0]  nb_q, nb_d;
    logic        dout_q, dout_d;
    logic [7:0]  regs_q [REG_COUNT];
    logic [7:0]  regs_d [REG_COUNT];
    logic [1:0]  flag_q, flag_d;
    logic [12:0] off_i_q, off_i_d, off_q_q, off_q_d;
    logic [10:0] gn_i_q, gn_i_d, gn_q_q, gn_q_d;
    logic [9:0]  ph_q, ph_d;
    logic        wr_en;
    logic [4:0]  wr_addr;
    logic [7:0]  wr_data, rd_byte, word_in;

    assign total   = 6'(({4'h0, nb_q} + 6'h01) << 3);
    assign word_in = {ish_q[6:0], din};

    // Read view: flags merge into the alarm register, holes read zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (32'(addr_q) < REG_COUNT && (addr_q <= scp_pkg::ADDR_LAST_LOW ||
            addr_q == scp_pkg::ADDR_CTRL_17))
        begin
            rd_byte = regs_q[addr_q];
        end
        if (addr_q == scp_pkg::ADDR_ALARM)
        begin
            rd_byte[scp_pkg::BIT_NEAR_TWO] = flag_q[0];
            rd_byte[scp_pkg::BIT_NEAR_ONE] = flag_q[1];
        end
    end

    // Framing, shifting and register updates
    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        ish_d   = ish_q;
        osh_d   = osh_q;
        addr_d  = addr_q;
        nb_d    = nb_q;
        dout_d  = dout_q;
        regs_d  = regs_q;
        off_i_d = off_i_q;
        off_q_d = off_q_q;
        gn_i_d  = gn_i_q;
        gn_q_d  = gn_q_q;
        ph_d    = ph_q;
        wr_en   = 1'b0;
        wr_addr = addr_q;
        wr_data = word_in;
        if (frame_idle)
        begin
            st_d   = scp_pkg::ST_INSTR;
            cnt_d  = 6'h00;
            dout_d = 1'b0;
        end
        else if (sclk_rise)
        begin
            ish_d = word_in;
            case (st_q)
                scp_pkg::ST_INSTR:
                begin
                    if (cnt_q == 6'h07)
                    begin
                        nb_d   = word_in[6:5];
                        addr_d = word_in[4:0];
                        st_d   = word_in[7] ? scp_pkg::ST_READ : scp_pkg::ST_WRITE;
                        cnt_d  = 6'h00;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                scp_pkg::ST_WRITE:
                begin
                    if (cnt_q < total)
                    begin
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q[2:0] == 3'h7)
                        begin
                            wr_en  = 1'b1;
                            addr_d = addr_q - 5'h01;
                        end
                    end
                end
                scp_pkg::ST_READ:
                begin
                    if (cnt_q < total)
                    begin
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q[2:0] == 3'h7)
                        begin
                            addr_d = addr_q - 5'h01;
                        end
                    end
                end
                default:
                begin
                    st_d = st_q;
                end
            endcase
        end
        else if (sclk_fall && st_q == scp_pkg::ST_READ)
        begin
            if (cnt_q == total)
            begin
                st_d   = scp_pkg::ST_TAIL;
                dout_d = 1'b0;
            end
            else if (cnt_q[2:0] == 3'h0)
            begin
                dout_d = rd_byte[7];
                osh_d  = {rd_byte[6:0], 1'b0};
            end
            else
            begin
                dout_d = osh_q[7];
                osh_d  = {osh_q[6:0], 1'b0};
            end
        end
        // Register write by kind: flags, commit points, normal, unmapped
        if (wr_en)
        begin
            if (wr_addr == scp_pkg::ADDR_ALARM)
            begin
                regs_d[wr_addr] = wr_data;
            end
            else if (32'(wr_addr) < REG_COUNT && (wr_addr <= scp_pkg::ADDR_LAST_LOW ||
                     wr_addr == scp_pkg::ADDR_CTRL_17))
            begin
                regs_d[wr_addr] = wr_data;
            end
            if (wr_addr == scp_pkg::ADDR_OFFSET_I_L)
            begin
                off_i_d = {regs_q[scp_pkg::ADDR_OFFSET_I_H][4:0], wr_data};
                off_q_d = {regs_q[scp_pkg::ADDR_OFFSET_Q_H][4:0],
                           regs_q[scp_pkg::ADDR_OFFSET_Q_L]};
            end
            if (wr_addr == scp_pkg::ADDR_GAIN_I_L)
            begin
                gn_i_d = {regs_q[scp_pkg::ADDR_GAIN_PH_H][4:2], wr_data};
                gn_q_d = {regs_q[scp_pkg::ADDR_GAIN_PH_H][7:5],
                          regs_q[scp_pkg::ADDR_GAIN_Q_L]};
                ph_d   = {regs_q[scp_pkg::ADDR_GAIN_PH_H][1:0],
                          regs_q[scp_pkg::ADDR_PHASE_L]};
            end
        end
        // Unmapped offsets stay zero: writes there have no effect
        // Sticky flags: written zero clears, a same-cycle event still sets
        flag_d = flag_q;
        if (wr_en && wr_addr == scp_pkg::ADDR_ALARM)
        begin
            flag_d = flag_q & {wr_data[scp_pkg::BIT_NEAR_ONE], wr_data[scp_pkg::BIT_NEAR_TWO]};
        end
        flag_d[0] = flag_d[0] | pin_q[scp_pkg::PIN_NEAR_TWO];
        flag_d[1] = flag_d[1] | pin_q[scp_pkg::PIN_NEAR_ONE];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q    <= scp_pkg::ST_INSTR;
            cnt_q   <= 6'h00;
            ish_q   <= 8'h00;
            osh_q   <= 8'h00;
            addr_q  <= 5'h00;
            nb_q    <= 2'h0;
            dout_q  <= 1'b0;
            flag_q  <= 2'h0;
            off_i_q <= 13'h0000;
            off_q_q <= 13'h0000;
            gn_i_q  <= 11'h000;
            gn_q_q  <= 11'h000;
            ph_q    <= 10'h000;
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs_q[i] <= scp_pkg::REG_RESET;
            end
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            ish_q   <= ish_d;
            osh_q   <= osh_d;
            addr_q  <= addr_d;
            nb_q    <= nb_d;
            dout_q  <= dout_d;
            flag_q  <= flag_d;
            off_i_q <= off_i_d;
            off_q_q <= off_q_d;
            gn_i_q  <= gn_i_d;
            gn_q_q  <= gn_q_d;
            ph_q    <= ph_d;
            regs_q  <= regs_d;
        end
    end

    // Control views of the bank
    logic [7:0] r_mode, r_if, r_pd;
    logic [1:0] clk_mode, pin_func;
    logic       four_wire, sleep, div_on;
    assign r_mode    = regs_q[scp_pkg::ADDR_CLOCK_MODE];
    assign r_if      = regs_q[scp_pkg::ADDR_INTERFACE];
    assign r_pd      = regs_q[scp_pkg::ADDR_POWER_DOWN];
    assign clk_mode  = regs_q[scp_pkg::ADDR_CTRL_01][1:0];
    assign four_wire = r_if[scp_pkg::BIT_FOUR_WIRE];
    assign pin_func  = r_if[scp_pkg::POS_PIN_FUNC +: 2];
    assign div_on    = (clk_mode == scp_pkg::MODE_DUAL_IN) || (clk_mode == scp_pkg::MODE_DUAL_OUT);
    assign sleep     = r_pd[scp_pkg::BIT_SLEEP] ||
                       (pin_func == scp_pkg::PIN_FUNC_SLEEP && pin_q[scp_pkg::PIN_SYNC_SLEEP]);

    // Registered outputs: pins, divider phase, sync and power control
    logic sdio_d, sdio_oe_d, al_d, al_oe_d, phase_d, sync_d, pend_q, pend_d;
    logic clk_oe_d, fifo_d, pdata_d, pd_diff_d, pd_rf_d, pd_conv_d, pd_chain_d;
    logic sync_pin;

    always_comb
    begin
        sdio_d    = dout_q;
        sdio_oe_d = !frame_idle && st_q == scp_pkg::ST_READ && !four_wire;
        al_d      = |flag_q;
        al_oe_d   = r_if[scp_pkg::BIT_ALARM_ON_PIN] && !four_wire;
        if (!frame_idle && four_wire && (st_q == scp_pkg::ST_READ || st_q == scp_pkg::ST_TAIL))
        begin
            al_d    = dout_q;
            al_oe_d = 1'b1;
        end
        else if (!frame_idle && st_q == scp_pkg::ST_READ)
        begin
            al_oe_d = 1'b0;
        end
        phase_d = sample_phase_q_o;
        if (div_on)
        begin
            phase_d = ~sample_phase_q_o;
            if (r_mode[scp_pkg::BIT_DIV_SYNC_EN] && marker_rise)
            begin
                phase_d = 1'b1;
            end
        end
        sync_pin = (pin_func == scp_pkg::PIN_FUNC_SYNC) && pin_q[scp_pkg::PIN_SYNC_SLEEP];
        pend_d   = pend_q;
        sync_d   = 1'b0;
        if (!r_mode[scp_pkg::BIT_SYNC_PHASE])
        begin
            sync_d = sync_pin && !sample_phase_q_o;
            pend_d = 1'b0;
        end
        else if (sample_phase_q_o)
        begin
            pend_d = pend_q | sync_pin;
        end
        else
        begin
            sync_d = pend_q;
            pend_d = 1'b0;
        end
        clk_oe_d   = !r_mode[scp_pkg::BIT_CLK_DRIVE_N];
        fifo_d     = r_mode[scp_pkg::BIT_FIFO_ENABLE] && clk_mode == scp_pkg::MODE_DUAL_IN;
        pdata_d    = r_mode[scp_pkg::BIT_DATA_TYPE];
        pd_diff_d  = r_pd[scp_pkg::BIT_PD_DIFF] || (sleep && r_pd[scp_pkg::BIT_AL_DIFF]);
        pd_rf_d    = r_pd[scp_pkg::BIT_PD_RF] || (sleep && r_pd[scp_pkg::BIT_AL_RF]);
        pd_conv_d  = r_pd[scp_pkg::BIT_PD_CONV] || (sleep && r_pd[scp_pkg::BIT_AL_CONV]);
        pd_chain_d = r_pd[scp_pkg::BIT_PD_CHAIN];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sdio_o            <= 1'b0;
            sdio_oe_o         <= 1'b0;
            alarm_sdo_o       <= 1'b0;
            alarm_sdo_oe_o    <= 1'b0;
            sample_phase_q_o  <= 1'b0;
            pend_q            <= 1'b0;
            sync_pulse_o      <= 1'b0;
            data_clock_oe_o   <= 1'b0;
            fifo_active_o     <= 1'b0;
            phase_data_mode_o <= 1'b0;
            diff_out_pd_o     <= 1'b0;
            rf_stage_pd_o     <= 1'b0;
            converter_pd_o    <= 1'b0;
            analog_chain_pd_o <= 1'b0;
        end
        else
        begin
            sdio_o            <= sdio_d;
            sdio_oe_o         <= sdio_oe_d;
            alarm_sdo_o       <= al_d;
            alarm_sdo_oe_o    <= al_oe_d;
            sample_phase_q_o  <= phase_d;
            pend_q            <= pend_d;
            sync_pulse_o      <= sync_d;
            data_clock_oe_o   <= clk_oe_d;
            fifo_active_o     <= fifo_d;
            phase_data_mode_o <= pdata_d;
            diff_out_pd_o     <= pd_diff_d;
            rf_stage_pd_o     <= pd_rf_d;
            converter_pd_o    <= pd_conv_d;
            analog_chain_pd_o <= pd_chain_d;
        end
    end

    // Committed correction values come straight from their flops
    assign offset_i_o   = off_i_q;
    assign offset_q_o   = off_q_q;
    assign gain_i_o     = gn_i_q;
    assign gain_q_o     = gn_q_q;
    assign phase_corr_o = ph_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic alarm_wr;
    assign alarm_wr = wr_en && wr_addr == scp_pkg::ADDR_ALARM;
    sequence tail_entered;
        four_wire && st_q == scp_pkg::ST_TAIL && !frame_idle;
    endsequence

    chk_flag_sticky: assert property (flag_q[0] && !alarm_wr |=> flag_q[0])
        else $error("near-two flag dropped without a clearing write");
    chk_near_two_set: assert property (pin_q[scp_pkg::PIN_NEAR_TWO] |=> flag_q[0])
        else $error("near-two event not captured");
    chk_near_one_set: assert property (pin_q[scp_pkg::PIN_NEAR_ONE] |=> flag_q[1])
        else $error("near-one event not captured");
    chk_instr_input: assert property (st_q == scp_pkg::ST_INSTR |=> !sdio_oe_o)
        else $error("data pin driven during instruction byte");
    chk_three_wire_rd: assert property (st_q == scp_pkg::ST_READ && !frame_idle && !four_wire
        |=> sdio_oe_o && !alarm_sdo_oe_o)
        else $error("three-wire read pin directions wrong");
    chk_tail_low: assert property (tail_entered |=> alarm_sdo_oe_o && !alarm_sdo_o)
        else $error("four-wire tail not driven low");
    chk_offset_hold: assert property (!(wr_en && wr_addr == scp_pkg::ADDR_OFFSET_I_L)
        |=> $stable(offset_i_o) && $stable(offset_q_o))
        else $error("offsets changed without commit write");
    chk_gain_hold: assert property (!(wr_en && wr_addr == scp_pkg::ADDR_GAIN_I_L)
        |=> $stable(gain_i_o) && $stable(phase_corr_o))
        else $error("gains changed without commit write");
    chk_fifo_bypass: assert property (clk_mode != scp_pkg::MODE_DUAL_IN |=> !fifo_active_o)
        else $error("fifo active outside dual-input mode");
    chk_pd_bit: assert property (r_pd[scp_pkg::BIT_PD_RF] |=> rf_stage_pd_o)
        else $error("rf stage not powered down");
    chk_marker_phase: assert property (marker_rise && div_on
        && r_mode[scp_pkg::BIT_DIV_SYNC_EN] |=> sample_phase_q_o)
        else $error("divider phase not aligned to marker");
endmodule : scp_serial_config_port

// ===== testbench/scp_host_model.sv
// Host serial master model: frames, shifts and samples the port.
// Assumes the bench clock; each sclk high level lasts HALF clocks, each low level at least HALF plus one.
`timescale 1ns/1ns
module scp_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic alarm_i,
    input  wire logic alarm_oe_i,
    output logic      sclk_o,
    output logic      frame_n_o,
    output logic      sdio_o,
    output logic      sdio_oe_o
);
    // Idle: frame high, sclk low, data pin released
    initial {sclk_o, frame_n_o, sdio_o, sdio_oe_o} = 4'h4;
    // One frame: instruction byte, then data bytes MSB first
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input logic four,
                        output logic [31:0] rd, output logic [1:0] tail);
        int nbit;
        nbit = 8 * (ins[6:5] + 1) + 8;
        rd = 32'h0;
        @(posedge clk_i) frame_n_o <= 1'b0;
        for (int i = 0; i < nbit; i++)
        begin
            @(posedge clk_i) sdio_o <= (i < 8) ? ins[7 - i] : wd[nbit - 1 - i];
            sdio_oe_o <= !(ins[7] && i >= 8);
            repeat (HALF) @(posedge clk_i);
            if (i >= 8)
            begin
                rd = {rd[30:0], four ? alarm_i : line_i};
            end
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge clk_i);
        tail = {alarm_oe_i, alarm_i};
        frame_n_o <= 1'b1;
        sdio_oe_o <= 1'b0;
        repeat (2 * HALF) @(posedge clk_i);
    endtask : xfer
endmodule : scp_host_model

// ===== testbench/tb.sv
// Bench for the serial configuration port, driven through the host model.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, sclk_i, frame_enable_n_i, sdio_i, host_d, host_oe, alarm;
    logic iq_phase_marker_i = 1'b0, sync_sleep_i = 1'b0, fifo_near_two_i = 1'b0;
    logic fifo_near_one_i = 1'b0, idle_q = 1'b0, sdio_o, sdio_oe_o, alarm_sdo_o, alarm_sdo_oe_o;
    logic sample_phase_q_o, sync_pulse_o, data_clock_oe_o, fifo_active_o, phase_data_mode_o;
    logic diff_out_pd_o, rf_stage_pd_o, converter_pd_o, analog_chain_pd_o;
    logic [12:0] offset_i_o, offset_q_o;
    logic [10:0] gain_i_o, gain_q_o;
    logic [9:0]  phase_corr_o;
    logic [31:0] rdata;
    logic [1:0]  tail;
    int          n_mismatch = 0, checks_done = 0, cycles = 0;
    int          n_sync = 0;
    logic        ph0;
    // Released pins toggle so a stale level never passes
    assign sdio_i = host_oe ? host_d : (sdio_oe_o ? sdio_o : idle_q);
    assign alarm = alarm_sdo_oe_o ? alarm_sdo_o : idle_q;
    scp_serial_config_port dut (.*);
    scp_host_model host (.clk_i(clk_i), .line_i(sdio_i), .alarm_i(alarm),
        .alarm_oe_i(alarm_sdo_oe_o), .sclk_o(sclk_i), .frame_n_o(frame_enable_n_i),
        .sdio_o(host_d), .sdio_oe_o(host_oe));
    always #2 clk_i = ~clk_i;
    // Idle pattern and hang guard
    always @(posedge clk_i)
    begin
        idle_q <= ~idle_q;
        cycles++;
        if (sync_pulse_o === 1'b1)
            n_sync++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [1:0] n, input logic [31:0] d);
        host.xfer({1'b0, n, a}, d, 1'b0, rdata, tail);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [1:0] n, input logic [31:0] exp,
                      input logic four, input string name);
        host.xfer({1'b1, n, a}, 32'h0, four, rdata, tail);
        check(name, exp, rdata);
    endtask : rd
    // Two-cycle sync pin pulse, then count the sync pulses it produced
    task automatic pulse_sync(input logic [31:0] exp, input string name);
        int base;
        base = n_sync;
        sync_sleep_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sync_sleep_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        check(name, exp, n_sync - base);
    endtask : pulse_sync
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    // Register sequences with expected values
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(5'h03, 2'h3, 32'h0, 1'b0, "reset");
        wr(5'h07, 2'h3, 32'hA1B2C3D4);
        rd(5'h07, 2'h3, 32'hA1B2C3D4, 1'b0, "rw4");
        check("sdo_idle", 1'b0, alarm_sdo_oe_o);
        wr(5'h03, 2'h0, 32'h40);
        rd(5'h05, 2'h1, 32'hC3D4, 1'b1, "four");
        check("tail", 2'h2, tail);
        check("release", 1'b0, alarm_sdo_oe_o);
        wr(5'h03, 2'h0, 32'h0);
        wr(5'h09, 2'h0, 32'h77);
        check("staged", 13'h0, offset_q_o);
        wr(5'h0B, 2'h3, 32'h0C155AA5);
        check("offs", {13'h15A5, 13'h0C5A}, {offset_i_o, offset_q_o});
        wr(5'h0F, 2'h3, 32'hB6334455);
        check("gains", {11'h555, 11'h544, 10'h233}, {gain_i_o, gain_q_o, phase_corr_o});
        fifo_near_two_i <= 1'b1;
        fifo_near_one_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        fifo_near_two_i <= 1'b0;
        fifo_near_one_i <= 1'b0;
        rd(5'h02, 2'h0, 32'h03, 1'b0, "flags");
        wr(5'h02, 2'h0, 32'h0);
        rd(5'h02, 2'h0, 32'h0, 1'b0, "cleared");
        wr(5'h06, 2'h0, 32'hF0);
        check("pd", 4'hF, {diff_out_pd_o, rf_stage_pd_o, converter_pd_o, analog_chain_pd_o});
        wr(5'h06, 2'h0, 32'h0B);
        check("sleep", 4'hA, {diff_out_pd_o, rf_stage_pd_o, converter_pd_o, analog_chain_pd_o});
        wr(5'h01, 2'h1, 32'h000C);
        check("mode_in", 3'h7, {fifo_active_o, phase_data_mode_o, data_clock_oe_o});
        wr(5'h01, 2'h1, 32'h0120);
        check("mode_out", 3'h0, {fifo_active_o, phase_data_mode_o, data_clock_oe_o});
        wr(5'h12, 2'h0, 32'hFF);
        rd(5'h12, 2'h0, 32'h0, 1'b0, "hole");
        wr(5'h03, 2'h0, 32'h20);
        wr(5'h00, 2'h0, 32'h80);
        @(posedge clk_i) ph0 = sample_phase_q_o;
        @(posedge clk_i) check("divide", 1'b1, ph0 ^ sample_phase_q_o);
        iq_phase_marker_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        iq_phase_marker_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        pulse_sync(1, "sync_i");
        wr(5'h00, 2'h0, 32'h82);
        pulse_sync(1, "sync_q");
        wr(5'h03, 2'h0, 32'h0);
        pulse_sync(0, "sync_off");
        finish_test();
    end
endmodule : tb
